// >>> sim/bpch_setup_model.sv
// Bridge core model: setup and translated base for the memory-0 window.
// Assumes values are loaded during reset, before any sizing access.
module bpch_setup_model (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   output logic [31:0]      setup_out,
   output logic [31:0]      xlat_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Loaded in reset, so the window is sized before the host sees it
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         setup_out <= 32'hFFFF0000;
         xlat_out  <= 32'h80000000;
      end
   end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for bpch_header over APB and the decode port.
// Assumes bpch_setup_model supplies fixed setup values.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                       clk_in, rstn_in, rev, pcix, pready, pslverr, e;
   logic [31:0]                prdata, setup, xlat, q;
   bpch_pkg::bpch_apb_req_type apb;
   bpch_pkg::bpch_txn_type     txn;
   bpch_pkg::bpch_dec_type     dec;
   int                         fails, cmp_count, cyc;
   bpch_setup_model bpch_setup_model_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .setup_out(setup), .xlat_out(xlat));
   bpch_header bpch_header_i (.clk_in(clk_in), .rstn_in(rstn_in), .apb_in(apb),
      .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
      .reverse_mode_in(rev), .pcix_mode_in(pcix), .mem0_setup_in(setup),
      .mem0_xlat_base_in(xlat), .txn_in(txn), .dec_out(dec));
   initial begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;
   end
   task give_verdict;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         give_verdict();
      end
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      apb <= '{1'h1, 1'h0, w, a, d};
      @(posedge clk_in);
      apb.penable <= 1'h1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'h1 && n < 10);
      if (pready !== 1'h1) fails++;
      q = prdata;
      e = pslverr;
      apb <= '0;
   endtask
   task rst(input logic r, input logic x);
      rstn_in <= 1'h0;
      rev <= r;
      pcix <= x;
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'h1;
      repeat (2) @(posedge clk_in);
   endtask
   task decode(input logic [31:0] a, input logic io);
      @(posedge clk_in);
      txn <= '{1'h1, a, io};
      @(posedge clk_in);
      txn <= '0;
      @(posedge clk_in);
   endtask
   initial begin
      rstn_in = 1'h0;
      rev = 1'h0;
      pcix = 1'h0;
      apb = '0;
      txn = '0;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      rst(1'h0, 1'h0);
      xfer(1'h0, 8'h08, 32'h0);
      chk("class", q >> 8, 32'h00068000);
      xfer(1'h0, 8'h14, 32'h0);
      chk("io_reset", q, 32'h00000001);
      decode(32'h00002000, 1'h0);
      chk("mem0_off", {30'h0, dec.csr_hit, dec.fwd_hit}, 32'h0);
      xfer(1'h1, 8'h0C, 32'hFFFFFFFF);
      xfer(1'h0, 8'h0C, 32'h0);
      chk("cls_lat_hdr", q, 32'h0000003C);
      xfer(1'h1, 8'h10, 32'hFFFFFFFF);
      xfer(1'h0, 8'h10, 32'h0);
      chk("mem0_base", q, 32'hFFFF0000);
      xfer(1'h1, 8'h14, 32'hFFFFFFFF);
      xfer(1'h0, 8'h14, 32'h0);
      chk("io_base", q, 32'hFFFFFF01);
      xfer(1'h0, 8'h40, 32'h0);
      chk("status", {e, q[30:0]}, 32'h00000003);
      decode(32'hFFFF0010, 1'h0);
      chk("csr_hit", {30'h0, dec.csr_hit, dec.fwd_hit}, 32'h2);
      decode(32'hFFFF2000, 1'h0);
      chk("fwd_hit", {30'h0, dec.csr_hit, dec.fwd_hit}, 32'h1);
      chk("fwd_addr", dec.fwd_addr, 32'h80002000);
      decode(32'hFFFFFF05, 1'h1);
      chk("io_hit", {31'h0, dec.csr_hit}, 32'h1);
      xfer(1'h1, 8'h08, 32'hFFFFFFFF);
      xfer(1'h0, 8'h08, 32'h0);
      chk("class_ro", q >> 8, 32'h00068000);
      xfer(1'h0, 8'h20, 32'h0);
      chk("unmapped", {e, q[30:0]}, 32'h80000000);
      $display("Forward mode test done");
      rst(1'h1, 1'h1);
      xfer(1'h0, 8'h0C, 32'h0);
      chk("lat_pcix", q, 32'h00004000);
      xfer(1'h1, 8'h0C, 32'h00001200);
      xfer(1'h0, 8'h0C, 32'h0);
      chk("lat_rw", q, 32'h00001200);
      xfer(1'h0, 8'h10, 32'h0);
      chk("mem0_rst", q, 32'h0);
      $display("Reverse mode test done");
      give_verdict();
   end
endmodule

// >>> verilog/bpch_header.sv
// Primary-side configuration header registers 08h..14h with APB access
// and memory-0 / IO window decoding. Mode and setup inputs come from
// the bridge core on the same clock and are held steady after reset.
//
// The APB interface to the registers is this design's own decision.
`include "bpch_params.svh"
module bpch_header (
   input  wire logic                      clk_in,
   input  wire logic                      rstn_in,
   input  wire bpch_pkg::bpch_apb_req_type apb_in,
   output logic                           pready_out,
   output logic                           pslverr_out,
   output logic [31:0]                    prdata_out,
   input  wire logic                      reverse_mode_in,
   input  wire logic                      pcix_mode_in,
   input  wire logic [31:0]               mem0_setup_in,
   input  wire logic [31:0]               mem0_xlat_base_in,
   input  wire bpch_pkg::bpch_txn_type    txn_in,
   output bpch_pkg::bpch_dec_type         dec_out
);
   logic [7:0]  cls;
   logic [7:0]  lat;
   logic [19:0] mem0_base;
   logic [23:0] io_base;
   logic        lat_loaded;
   logic [7:0]  next_cls;
   logic [7:0]  next_lat;
   logic [19:0] next_mem0_base;
   logic [23:0] next_io_base;
   logic        next_lat_loaded;
   logic        next_pready;
   logic        next_pslverr;
   logic [31:0] next_prdata;
   bpch_pkg::bpch_dec_type next_dec;
   logic        wr_acc;
   logic        rd_acc;
   logic        mapped;
   logic [31:0] mem0_reg;
   logic [31:0] io_reg;
   logic [19:0] mem0_mask;
   logic [31:0] offset;

   // Single-wait access: setup, access with pready high
   assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite && !pready_out;
   assign rd_acc = apb_in.psel && apb_in.penable && !apb_in.pwrite && !pready_out;
   assign mem0_reg = {mem0_base, `BPCH_MEM0_LOW};
   assign io_reg = {io_base, `BPCH_IO_LOW};
   assign mem0_mask = mem0_setup_in[31:12];

   always_comb begin
      mapped = 1'b1;
      unique case (apb_in.paddr)
         `BPCH_OFS_REV_CLASS,
         `BPCH_OFS_CLS_LAT_HDR,
         `BPCH_OFS_MEM0_BASE,
         `BPCH_OFS_IO_BASE,
         `BPCH_OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      next_cls = cls;
      next_lat = lat;
      next_mem0_base = mem0_base;
      next_io_base = io_base;
      next_lat_loaded = lat_loaded;
      // Mode straps are sampled once after reset release
      if (!lat_loaded) begin
         next_lat_loaded = 1'b1;
         next_lat = (reverse_mode_in && pcix_mode_in) ? `BPCH_LAT_RESET_PCIX
                                                      : `BPCH_LAT_RESET_PCI;
      end
      if (wr_acc) begin
         unique case (apb_in.paddr)
            `BPCH_OFS_CLS_LAT_HDR: begin
               next_cls = apb_in.pwdata[7:0] & `BPCH_CLS_WR_MASK;
               if (reverse_mode_in) begin
                  next_lat = apb_in.pwdata[15:8];
               end
            end
            `BPCH_OFS_MEM0_BASE: begin
               next_mem0_base = (apb_in.pwdata[31:12] & mem0_mask)
                              | (mem0_base & ~mem0_mask);
            end
            `BPCH_OFS_IO_BASE: begin
               next_io_base = apb_in.pwdata[31:8];
            end
            default: begin
               next_cls = cls;
            end
         endcase
      end
   end

   always_comb begin
      next_pready = apb_in.psel && apb_in.penable && !pready_out;
      next_pslverr = (wr_acc || rd_acc) && !mapped;
      next_prdata = 32'h00000000;
      if (rd_acc) begin
         unique case (apb_in.paddr)
            `BPCH_OFS_REV_CLASS: next_prdata = {`BPCH_CLASS_CODE, `BPCH_REVISION};
            `BPCH_OFS_CLS_LAT_HDR: next_prdata = {8'h00, `BPCH_HDR_TYPE,
                                                  (reverse_mode_in ? lat : 8'h00),
                                                  cls};
            `BPCH_OFS_MEM0_BASE: next_prdata = mem0_reg;
            `BPCH_OFS_IO_BASE: next_prdata = io_reg;
            `BPCH_OFS_STATUS: next_prdata = {30'h00000000, io_base != 24'h000000,
                                             mem0_base != 20'h00000};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   // Window decode for primary transactions
   always_comb begin
      offset = txn_in.addr - mem0_reg;
      next_dec = '0;
      if (txn_in.valid && txn_in.is_io) begin
         next_dec.csr_hit = txn_in.addr[31:8] == io_base;
      end else if (txn_in.valid && mem0_base != 20'h00000) begin
         if ((txn_in.addr[31:12] & mem0_setup_in[31:12]) == mem0_base) begin
            if (offset[31:12] == 20'h00000) begin
               next_dec.csr_hit = 1'b1;
            end else begin
               next_dec.fwd_hit = 1'b1;
               next_dec.fwd_addr = mem0_xlat_base_in + offset;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cls <= 8'h00;
         lat <= 8'h00;
         mem0_base <= 20'h00000;
         io_base <= 24'h000000;
         lat_loaded <= 1'b0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
         dec_out <= '0;
      end else begin
         cls <= next_cls;
         lat <= next_lat;
         mem0_base <= next_mem0_base;
         io_base <= next_io_base;
         lat_loaded <= next_lat_loaded;
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
         prdata_out <= next_prdata;
         dec_out <= next_dec;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   cls_low_zero_a: assert property (cls[1:0] == 2'b00 && cls[7:6] == 2'b00)
      else $error("cache line reserved bits set");
   cls_write_a: assert property (wr_acc && apb_in.paddr == `BPCH_OFS_CLS_LAT_HDR
      |=> cls == ($past(apb_in.pwdata[7:0]) & 8'h3C))
      else $error("cache line write wrong");
   lat_fwd_a: assert property (pready_out && !pslverr_out && !reverse_mode_in
      && $past(apb_in.paddr) == `BPCH_OFS_CLS_LAT_HDR && $past(rd_acc)
      |-> prdata_out[15:8] == 8'h00)
      else $error("forward latency not zero");
   class_read_a: assert property (rd_acc && apb_in.paddr == `BPCH_OFS_REV_CLASS
      |=> pready_out && prdata_out[31:8] == 24'h068000)
      else $error("class code wrong");
   hdr_read_a: assert property (rd_acc && apb_in.paddr == `BPCH_OFS_CLS_LAT_HDR
      |=> prdata_out[31:16] == 16'h0000)
      else $error("header type not zero");
   mem0_ro_a: assert property (wr_acc |=> ((mem0_base ^ $past(mem0_base))
      & ~$past(mem0_setup_in[31:12])) == 20'h00000)
      else $error("read-only base bit changed");
   mem0_off_a: assert property (mem0_base == 20'h00000 && !txn_in.is_io
      |=> !dec_out.csr_hit && !dec_out.fwd_hit)
      else $error("disabled window decoded");
   io_low_a: assert property (rd_acc && apb_in.paddr == `BPCH_OFS_IO_BASE
      |=> prdata_out[7:0] == 8'h01)
      else $error("IO base low bits wrong");
   fwd_xlat_a: assert property (dec_out.fwd_hit |-> dec_out.fwd_addr[11:0]
      == $past(txn_in.addr[11:0]) + mem0_xlat_base_in[11:0])
      else $error("translation wrong");
   wr_cov_c: cover property (wr_acc && apb_in.paddr == `BPCH_OFS_MEM0_BASE);
   csr_cov_c: cover property (dec_out.csr_hit);
   fwd_cov_c: cover property (dec_out.fwd_hit);
   err_cov_c: cover property (pslverr_out);
   lat_rw_c: cover property (wr_acc && reverse_mode_in && apb_in.paddr == `BPCH_OFS_CLS_LAT_HDR);

   // Bus answer shape, register updates and window decode
   pready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("pready held too long");
   err_pair_a: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h00000000)
      else $error("read data outside answer");
   rev_read_a: assert property (rd_acc && apb_in.paddr == `BPCH_OFS_REV_CLASS
      |=> prdata_out[7:0] == `BPCH_REVISION)
      else $error("revision wrong");
   lat_load_a: assert property ($rose(lat_loaded) |-> lat == ((reverse_mode_in && pcix_mode_in)
      ? `BPCH_LAT_RESET_PCIX : `BPCH_LAT_RESET_PCI))
      else $error("latency reset value wrong");
   lat_ro_a: assert property (lat_loaded && wr_acc && !reverse_mode_in
      |=> lat == $past(lat))
      else $error("forward latency written");
   io_wr_a: assert property (wr_acc && apb_in.paddr == `BPCH_OFS_IO_BASE
      |=> io_base == $past(apb_in.pwdata[31:8]))
      else $error("IO base write wrong");
   unmapped_wr_a: assert property (wr_acc && !mapped |=> cls == $past(cls)
      && mem0_base == $past(mem0_base) && io_base == $past(io_base))
      else $error("unmapped write changed state");
   io_dec_a: assert property (txn_in.valid && txn_in.is_io && txn_in.addr[31:8] == io_base
      |=> dec_out.csr_hit && !dec_out.fwd_hit)
      else $error("IO access not decoded");
   hit_excl_a: assert property (!(dec_out.csr_hit && dec_out.fwd_hit))
      else $error("both decode hits set");
   mem0_csr_a: assert property (txn_in.valid && !txn_in.is_io && mem0_base != 20'h00000
      && txn_in.addr[31:12] == mem0_base |=> dec_out.csr_hit)
      else $error("lowest window page not CSR");
   fwd_gate_a: assert property (dec_out.fwd_hit |-> $past(txn_in.valid)
      && !$past(txn_in.is_io))
      else $error("forward without memory access");
endmodule

// >>> verilog/bpch_params.svh
// Constants of the primary configuration header block.
// Assumes an APB slave with word-aligned byte addresses.
// Summary of operation
// - Class code reads fixed bridge, other-bridge values
// - Cache line bits 1:0 read zero
// - Cache line bits 5:2 writable, reset zero
// - Cache line bits 7:6 read zero
// - Latency timer RO forward, RW reverse, mode reset
// - Header type byte and upper byte read zero
// - Memory-0 base low bits read zero
// - Memory-0 base bit writable when setup bit set
// - Memory-0 window sized 4KB to 2GB by setup
// - Lowest 4KB hits CSRs, rest forwards downstream
// - Forwarded addresses translated with translated base
// - Zero memory-0 base field disables memory-0 decoding, not IO decoding
// - Setup register loaded externally before sizing
// - IO base bit 0 one, bits 7:1 zero
// - IO accesses matching bits 31:8 hit CSRs
`ifndef BPCH_PARAMS_SVH
`define BPCH_PARAMS_SVH
`define BPCH_OFS_REV_CLASS   8'h08
`define BPCH_OFS_CLS_LAT_HDR 8'h0C
`define BPCH_OFS_MEM0_BASE   8'h10
`define BPCH_OFS_IO_BASE     8'h14
`define BPCH_OFS_STATUS      8'h40
// Revision value is arbitrary
`define BPCH_REVISION        8'h5A
`define BPCH_CLASS_CODE      24'h068000
`define BPCH_CLS_WR_MASK     8'h3C
`define BPCH_LAT_RESET_PCI   8'h00
`define BPCH_LAT_RESET_PCIX  8'h40
`define BPCH_HDR_TYPE        8'h00
`define BPCH_MEM0_LOW        12'h000
`define BPCH_IO_LOW          8'h01
`define BPCH_MEM0_MIN_SETUP  20'hFFFFF
`endif

// >>> verilog/bpch_pkg.sv
// Types of the primary configuration header block.
// Assumes bpch_params.svh holds the numeric constants.
package bpch_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } bpch_apb_req_type;
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        is_io;
   } bpch_txn_type;
   typedef struct packed {
      logic        csr_hit;
      logic        fwd_hit;
      logic [31:0] fwd_addr;
   } bpch_dec_type;
endpackage
